// ===== jlr_defs.vh
// constants for the lockout recovery block
`ifndef JLR_DEFS_VH
`define JLR_DEFS_VH

`define JLR_ADDR_W          3
`define JLR_DATA_W          16

`define JLR_OFF_DIVIDER     3'h0
`define JLR_OFF_PROTECT     3'h1
`define JLR_OFF_COMMAND     3'h2
`define JLR_OFF_KEY_ENTRY   3'h3
`define JLR_OFF_STATUS      3'h4

`define JLR_DIV_PRESCALE    6
`define JLR_DIV_LSB         0
`define JLR_DIV_MSB         5
`define JLR_DIV_W           7
`define JLR_PROT_W          8
`define JLR_RST_DIVIDER     7'h00
`define JLR_RST_PROTECT     8'h00

`define JLR_CMD_ERASE       0
`define JLR_CMD_CLR_DONE    1

`define JLR_ST_DONE         0
`define JLR_ST_UNLOCKED     1
`define JLR_ST_SECURE       2
`define JLR_ST_BUSY         3
`define JLR_ST_RECOVERY     4

`define JLR_IR_W            4
`define JLR_IR_CAPTURE      4'h1
`define JLR_IR_BYPASS       4'hF

`define JLR_PRESCALE_LAST   3'h7

`define JLR_TAP_RESET       4'h0
`define JLR_TAP_IDLE        4'h1
`define JLR_TAP_SEL_DR      4'h2
`define JLR_TAP_CAP_DR      4'h3
`define JLR_TAP_SHIFT_DR    4'h4
`define JLR_TAP_EXIT1_DR    4'h5
`define JLR_TAP_PAUSE_DR    4'h6
`define JLR_TAP_EXIT2_DR    4'h7
`define JLR_TAP_UPD_DR      4'h8
`define JLR_TAP_SEL_IR      4'h9
`define JLR_TAP_CAP_IR      4'hA
`define JLR_TAP_SHIFT_IR    4'hB
`define JLR_TAP_EXIT1_IR    4'hC
`define JLR_TAP_PAUSE_IR    4'hD
`define JLR_TAP_EXIT2_IR    4'hE
`define JLR_TAP_UPD_IR      4'hF

`endif

// ===== jlr_clkgen.v
// flash timing tick generator: sys/2, optional /8, then /(div+1)
`timescale 1ns/1ps
`default_nettype none
`include "jlr_defs.vh"

module jlr_clkgen
(
  input  wire       clk,
  input  wire       reset_n,
  input  wire       clear,
  input  wire       prescale_by_eight_bit,
  input  wire [5:0] erase_clock_divider_field,
  output reg        tick_reg
);

  reg       half_reg;
  reg [2:0] pre_reg;
  reg [5:0] div_reg;
  wire      stage1;
  wire      stage2;

  assign stage1 = half_reg;
  assign stage2 = stage1 & (~prescale_by_eight_bit | (pre_reg == `JLR_PRESCALE_LAST));

  always @(posedge clk)
  begin
    if (!reset_n || clear)
    begin
      half_reg <= 1'b0;
      pre_reg  <= 3'h0;
      div_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      half_reg <= ~half_reg;
      tick_reg <= 1'b0;
      if (stage1)
        pre_reg <= pre_reg + 3'h1;
      if (stage2)
      begin
        if (div_reg == erase_clock_divider_field)
        begin
          div_reg  <= 6'h00;
          tick_reg <= 1'b1;
        end
        else
          div_reg <= div_reg + 6'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ===== jlr_erase_seq.v
// mass erase sequencer timed by flash ticks
`timescale 1ns/1ps
`default_nettype none
`include "jlr_defs.vh"

module jlr_erase_seq
#(
  parameter ERASE_TICKS = 16'h0100
)
(
  input  wire clk,
  input  wire reset_n,
  input  wire start,
  input  wire abort,
  input  wire tick,
  output reg  busy_reg,
  output reg  done_reg
);

  reg [15:0] cnt_reg;

  always @(posedge clk)
  begin
    if (!reset_n || abort)
    begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg  <= 16'h0000;
    end
    else
    begin
      done_reg <= 1'b0;
      if (!busy_reg && start)
      begin
        busy_reg <= 1'b1;
        cnt_reg  <= 16'h0000;
      end
      else if (busy_reg && tick)
      begin
        if (cnt_reg == ERASE_TICKS - 16'h0001)
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ===== jlr_lockout_recovery.v
// lockout recovery: test port, recovery data register, erase control, security
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "jlr_defs.vh"

// Operation
// - recovery erases all flash incl. config, ignoring protection; unsecure only after reset
// - recovery instruction selects a 7-bit data register holding the divider
// - during recovery the test register replaces the divider register value
// - bit 6 drives divide-by-eight, bits 5..0 drive the divider field
// - input is sys/2, /8 if prescale set, then /(div+1)
// - after data update, erase starts on entering Run-Test/Idle
// - backdoor key unlock allowed only when key enable is set
// - at reset, debug memory reads are disabled from stored security bytes
module jlr_lockout_recovery
#(
  parameter IR_RECOVERY = 4'hB,
  parameter KEY_W       = 16,
  parameter ERASE_TICKS = 16'h0100
)
(
  input  wire                   clk,
  input  wire                   reset_n,
  input  wire                   tck,
  input  wire                   tms,
  input  wire                   tdi,
  input  wire                   trst_n,
  output reg                    tdo_reg,
  output reg                    tdo_oe_n_reg,
  input  wire [`JLR_ADDR_W-1:0] addr,
  input  wire [`JLR_DATA_W-1:0] wdata,
  input  wire                   wr,
  input  wire                   rd,
  output reg  [`JLR_DATA_W-1:0] rdata_reg,
  input  wire                   cfg_security_on,
  input  wire                   backdoor_key_enable,
  input  wire [KEY_W-1:0]       backdoor_key_stored,
  output wire                   flash_erase_all,
  output wire                   flash_erase_done,
  output wire                   flash_timing_tick,
  output reg                    core_debug_read_disable_reg,
  output reg                    recovery_active_reg
);

  reg  [3:0]            tap_reg;
  reg  [3:0]            tap_next;
  reg                   tck_d_reg;
  reg  [`JLR_IR_W-1:0]  ir_reg;
  reg  [`JLR_IR_W-1:0]  ir_shift_reg;
  reg  [`JLR_DIV_W-1:0] dr_shift_reg;
  reg  [`JLR_DIV_W-1:0] dr_hold_reg;
  reg                   dr_updated_reg;
  reg                   bypass_reg;
  reg  [`JLR_DIV_W-1:0] divider_reg;
  reg  [`JLR_PROT_W-1:0] protect_reg;
  reg                   done_sticky_reg;
  reg                   secure_reg;
  reg                   key_en_reg;
  reg                   unlocked_reg;
  reg                   load_pend_reg;
  reg                   start_reg;
  reg                   rec_start_reg;
  wire                  tck_rise;
  wire                  tck_fall;
  wire                  is_recovery;
  wire                  busy;
  wire                  done;
  wire                  abort;
  wire [`JLR_DIV_W-1:0] div_sel;

  function is_shift;
    input [3:0] st;
    begin
      is_shift = (st == `JLR_TAP_SHIFT_DR) || (st == `JLR_TAP_SHIFT_IR);
    end
  endfunction

  function bus_hit;
    input [`JLR_ADDR_W-1:0] a;
    input [`JLR_ADDR_W-1:0] off;
    begin
      bus_hit = (a == off);
    end
  endfunction

  assign tck_rise    = tck & ~tck_d_reg;
  assign tck_fall    = ~tck & tck_d_reg;
  assign is_recovery = (ir_reg == IR_RECOVERY);
  assign abort       = ~trst_n;
  // the test register value steers the divider while recovery owns the erase
  assign div_sel     = recovery_active_reg ? dr_hold_reg : divider_reg;

  // tap state transitions
  always @*
  begin
    tap_next = tap_reg;
    case (tap_reg)
      `JLR_TAP_RESET:    tap_next = tms ? `JLR_TAP_RESET    : `JLR_TAP_IDLE;
      `JLR_TAP_IDLE:     tap_next = tms ? `JLR_TAP_SEL_DR   : `JLR_TAP_IDLE;
      `JLR_TAP_SEL_DR:   tap_next = tms ? `JLR_TAP_SEL_IR   : `JLR_TAP_CAP_DR;
      `JLR_TAP_CAP_DR:   tap_next = tms ? `JLR_TAP_EXIT1_DR : `JLR_TAP_SHIFT_DR;
      `JLR_TAP_SHIFT_DR: tap_next = tms ? `JLR_TAP_EXIT1_DR : `JLR_TAP_SHIFT_DR;
      `JLR_TAP_EXIT1_DR: tap_next = tms ? `JLR_TAP_UPD_DR   : `JLR_TAP_PAUSE_DR;
      `JLR_TAP_PAUSE_DR: tap_next = tms ? `JLR_TAP_EXIT2_DR : `JLR_TAP_PAUSE_DR;
      `JLR_TAP_EXIT2_DR: tap_next = tms ? `JLR_TAP_UPD_DR   : `JLR_TAP_SHIFT_DR;
      `JLR_TAP_UPD_DR:   tap_next = tms ? `JLR_TAP_SEL_DR   : `JLR_TAP_IDLE;
      `JLR_TAP_SEL_IR:   tap_next = tms ? `JLR_TAP_RESET    : `JLR_TAP_CAP_IR;
      `JLR_TAP_CAP_IR:   tap_next = tms ? `JLR_TAP_EXIT1_IR : `JLR_TAP_SHIFT_IR;
      `JLR_TAP_SHIFT_IR: tap_next = tms ? `JLR_TAP_EXIT1_IR : `JLR_TAP_SHIFT_IR;
      `JLR_TAP_EXIT1_IR: tap_next = tms ? `JLR_TAP_UPD_IR   : `JLR_TAP_PAUSE_IR;
      `JLR_TAP_PAUSE_IR: tap_next = tms ? `JLR_TAP_EXIT2_IR : `JLR_TAP_PAUSE_IR;
      `JLR_TAP_EXIT2_IR: tap_next = tms ? `JLR_TAP_UPD_IR   : `JLR_TAP_SHIFT_IR;
      `JLR_TAP_UPD_IR:   tap_next = tms ? `JLR_TAP_SEL_DR   : `JLR_TAP_IDLE;
      default:           tap_next = `JLR_TAP_RESET;
    endcase
  end

  // test port: instruction and recovery data registers
  always @(posedge clk)
  begin
    if (!reset_n || !trst_n)
    begin
      tck_d_reg      <= 1'b0;
      tap_reg        <= `JLR_TAP_RESET;
      ir_reg         <= `JLR_IR_BYPASS;
      ir_shift_reg   <= `JLR_IR_CAPTURE;
      dr_shift_reg   <= `JLR_RST_DIVIDER;
      dr_hold_reg    <= `JLR_RST_DIVIDER;
      dr_updated_reg <= 1'b0;
      bypass_reg     <= 1'b0;
      tdo_reg        <= 1'b0;
      tdo_oe_n_reg   <= 1'b1;
      rec_start_reg  <= 1'b0;
    end
    else
    begin
      tck_d_reg     <= tck;
      rec_start_reg <= 1'b0;
      if (tck_rise)
      begin
        tap_reg <= tap_next;
        case (tap_reg)
          `JLR_TAP_RESET:
            ir_reg <= `JLR_IR_BYPASS;
          `JLR_TAP_CAP_IR:
            ir_shift_reg <= `JLR_IR_CAPTURE;
          `JLR_TAP_SHIFT_IR:
            ir_shift_reg <= {tdi, ir_shift_reg[`JLR_IR_W-1:1]};
          `JLR_TAP_UPD_IR:
            ir_reg <= ir_shift_reg;
          `JLR_TAP_CAP_DR:
          begin
            dr_shift_reg <= dr_hold_reg;
            bypass_reg   <= 1'b0;
          end
          `JLR_TAP_SHIFT_DR:
          begin
            if (is_recovery)
              dr_shift_reg <= {tdi, dr_shift_reg[`JLR_DIV_W-1:1]};
            else
              bypass_reg <= tdi;
          end
          `JLR_TAP_UPD_DR:
          begin
            // a running erase keeps its divider
            if (is_recovery && !busy)
            begin
              dr_hold_reg    <= dr_shift_reg;
              dr_updated_reg <= 1'b1;
            end
          end
          `JLR_TAP_IDLE:
          begin
            // stays here while erase runs; the entry edge starts it
          end
          default:
          begin
          end
        endcase
        // start when entering Run-Test/Idle with a fresh divider, straight from update too
        if (tap_next == `JLR_TAP_IDLE && tap_reg != `JLR_TAP_IDLE && is_recovery && !busy &&
            (dr_updated_reg || tap_reg == `JLR_TAP_UPD_DR))
        begin
          rec_start_reg  <= 1'b1;
          dr_updated_reg <= 1'b0;
        end
      end
      if (tck_fall)
      begin
        tdo_oe_n_reg <= ~is_shift(tap_reg);
        if (tap_reg == `JLR_TAP_SHIFT_IR)
          tdo_reg <= ir_shift_reg[0];
        else if (tap_reg == `JLR_TAP_SHIFT_DR)
          tdo_reg <= is_recovery ? dr_shift_reg[0] : bypass_reg;
      end
    end
  end

  // recovery ownership of the erase and divider
  always @(posedge clk)
  begin
    if (!reset_n || abort)
      recovery_active_reg <= 1'b0;
    else if (rec_start_reg)
      recovery_active_reg <= 1'b1;
    else if (done)
      recovery_active_reg <= 1'b0;
  end

  // register bus, security and backdoor
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      divider_reg     <= `JLR_RST_DIVIDER;
      protect_reg     <= `JLR_RST_PROTECT;
      done_sticky_reg <= 1'b0;
      rdata_reg       <= {`JLR_DATA_W{1'b0}};
      start_reg       <= 1'b0;
      secure_reg      <= 1'b1;
      key_en_reg      <= 1'b0;
      unlocked_reg    <= 1'b0;
      load_pend_reg   <= 1'b1;
      core_debug_read_disable_reg <= 1'b1;
    end
    else
    begin
      start_reg <= 1'b0;
      // security state is taken from stored bytes only just after reset
      if (load_pend_reg)
      begin
        load_pend_reg <= 1'b0;
        secure_reg    <= cfg_security_on;
        key_en_reg    <= backdoor_key_enable;
      end
      core_debug_read_disable_reg <= secure_reg & ~unlocked_reg;
      if (wr && bus_hit(addr, `JLR_OFF_DIVIDER))
        divider_reg <= wdata[`JLR_DIV_W-1:0];
      if (wr && bus_hit(addr, `JLR_OFF_PROTECT))
        protect_reg <= wdata[`JLR_PROT_W-1:0];
      // software erase honours protection and yields to recovery
      if (wr && bus_hit(addr, `JLR_OFF_COMMAND) && wdata[`JLR_CMD_ERASE] &&
          protect_reg == `JLR_RST_PROTECT && !busy && !recovery_active_reg)
        start_reg <= 1'b1;
      if (wr && bus_hit(addr, `JLR_OFF_KEY_ENTRY) && key_en_reg &&
          wdata[KEY_W-1:0] == backdoor_key_stored)
        unlocked_reg <= 1'b1;
      if (done)
        done_sticky_reg <= 1'b1;
      else if (wr && bus_hit(addr, `JLR_OFF_COMMAND) && wdata[`JLR_CMD_CLR_DONE])
        done_sticky_reg <= 1'b0;
      rdata_reg <= {`JLR_DATA_W{1'b0}};
      if (rd)
      begin
        if (bus_hit(addr, `JLR_OFF_DIVIDER))
          rdata_reg[`JLR_DIV_W-1:0] <= divider_reg;
        else if (bus_hit(addr, `JLR_OFF_PROTECT))
          rdata_reg[`JLR_PROT_W-1:0] <= protect_reg;
        else if (bus_hit(addr, `JLR_OFF_STATUS))
        begin
          rdata_reg[`JLR_ST_DONE]     <= done_sticky_reg;
          rdata_reg[`JLR_ST_UNLOCKED] <= unlocked_reg;
          rdata_reg[`JLR_ST_SECURE]   <= secure_reg;
          rdata_reg[`JLR_ST_BUSY]     <= busy;
          rdata_reg[`JLR_ST_RECOVERY] <= recovery_active_reg;
        end
      end
    end
  end

  jlr_clkgen u_clkgen
  (
    .clk                       (clk),
    .reset_n                   (reset_n),
    .clear                     (rec_start_reg),
    .prescale_by_eight_bit     (div_sel[`JLR_DIV_PRESCALE]),
    .erase_clock_divider_field (div_sel[`JLR_DIV_MSB:`JLR_DIV_LSB]),
    .tick_reg                  (flash_timing_tick)
  );

  // recovery start needs no protection check: the whole array goes
  jlr_erase_seq #(.ERASE_TICKS(ERASE_TICKS)) u_seq
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (rec_start_reg | start_reg),
    .abort    (abort),
    .tick     (flash_timing_tick),
    .busy_reg (busy),
    .done_reg (done)
  );

  assign flash_erase_all  = busy;
  assign flash_erase_done = done;

endmodule
`default_nettype wire

// ===== jlr_lockout_recovery_assertions.sv
// checker for the lockout recovery block ports
`timescale 1ns/1ps
`default_nettype none
module jlr_recovery_checker
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        trst_n,
  input wire logic        rd,
  input wire logic [15:0] rdata_reg,
  input wire logic        backdoor_key_enable,
  input wire logic        cfg_security_on,
  input wire logic        flash_erase_all,
  input wire logic        flash_erase_done,
  input wire logic        flash_timing_tick,
  input wire logic        core_debug_read_disable_reg,
  input wire logic        recovery_active_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_erase_end;
    $fell(flash_erase_all) ##1 !flash_erase_done && !recovery_active_reg;
  endsequence

  // erase seen two edges after the test-clock rise that entered idle
  sequence s_idle_entry;
    $rose(flash_erase_all) && $past(tck, 2) && !$past(tck, 3) && !$past(tms, 2);
  endsequence

  AST_DONE_ENDS: assert property (flash_erase_done |-> s_erase_end)
    else $error("erase end not aligned with done");
  AST_ERASE_STOP: assert property ($fell(flash_erase_all) |-> flash_erase_done || !$past(trst_n))
    else $error("erase stopped early");
  AST_ABORT: assert property (flash_erase_all && !trst_n |=> !flash_erase_all && !recovery_active_reg && !flash_erase_done)
    else $error("test reset did not abort erase");
  AST_START: assert property ($rose(recovery_active_reg) |-> s_idle_entry)
    else $error("recovery started off idle entry");
  AST_TICK_PULSE: assert property (flash_timing_tick |=> !flash_timing_tick)
    else $error("timing tick longer than one cycle");
  AST_RDATA_IDLE: assert property (!rd |=> rdata_reg == 16'h0000)
    else $error("read data without read");
  AST_SECURE_LOAD: assert property ($rose(reset_n) ##1 1 |=> core_debug_read_disable_reg == $past(cfg_security_on, 2))
    else $error("debug disable not loaded from security");
  AST_NO_RELOCK: assert property (!$rose(core_debug_read_disable_reg))
    else $error("debug disable rose outside reset");
  AST_KEY_ONLY: assert property ($fell(core_debug_read_disable_reg) && $past(reset_n, 3) |-> backdoor_key_enable)
    else $error("unlock without key enable");
endmodule

bind jlr_lockout_recovery jlr_recovery_checker jlr_recovery_checker_i
(
  .clk, .reset_n, .tck, .tms, .trst_n, .rd, .rdata_reg, .backdoor_key_enable, .cfg_security_on,
  .flash_erase_all, .flash_erase_done, .flash_timing_tick, .core_debug_read_disable_reg,
  .recovery_active_reg
);
`default_nettype wire

// ===== jlr_tap_master.sv
// test-port master model clocked from the system clock
`timescale 1ns/1ps
`default_nettype none
module jlr_tap_master
(
  input  wire logic clk,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n,
  input  wire logic tdo
);
  logic [6:0] cap;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
    cap = 7'h00;
  end

  // one test-clock period, two clocks high and three low; tck rests low
  task automatic step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    @(posedge clk) tck <= 1'b1;
    repeat (2) @(posedge clk);
    tck <= 1'b0;
    tdi <= ~d;
    repeat (2) @(posedge clk);
  endtask

  task automatic tap_reset;
    trst_n <= 1'b0;
    repeat (2) @(posedge clk);
    trst_n <= 1'b1;
    step(1'b0, 1'b0);
  endtask

  // from idle: capture, shift n bits lsb first, update, back to idle and stay
  task automatic scan(input logic ir, input logic [6:0] v, input int n);
    step(1'b1, 1'b0);
    if (ir)
      step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      cap = {tdo, cap[6:1]};
      step(i == n - 1, v[i]);
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the lockout recovery block
`timescale 1ns/1ps
`default_nettype none
`include "jlr_defs.vh"
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        cfg_security_on = 1'b1;
  logic        backdoor_key_enable = 1'b0;
  wire logic   tck, tms, tdi, trst_n, tdo_reg, tdo_oe_n_reg, flash_erase_all;
  wire logic   flash_erase_done, flash_timing_tick, core_debug_read_disable_reg;
  wire logic   recovery_active_reg;
  wire logic [15:0] rdata_reg;
  int          fail_count = 0;
  int          n_checks = 0;

  always #50 clk = ~clk;

  jlr_lockout_recovery #(.ERASE_TICKS(16'h0004)) jlr_lockout_recovery_i
  (
    .clk, .reset_n, .tck, .tms, .tdi, .trst_n, .tdo_reg, .tdo_oe_n_reg, .addr, .wdata, .wr,
    .rd, .rdata_reg, .cfg_security_on, .backdoor_key_enable, .backdoor_key_stored(16'hA5C3),
    .flash_erase_all, .flash_erase_done, .flash_timing_tick, .core_debug_read_disable_reg,
    .recovery_active_reg
  );

  // undriven data-out line shows the inverse of its last level
  jlr_tap_master jlr_tap_master_i
  (
    .clk, .tck, .tms, .tdi, .trst_n, .tdo(tdo_oe_n_reg ? ~tdo_reg : tdo_reg)
  );

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata_reg, e);
  endtask

  task automatic chip_reset;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(16'({tdo_oe_n_reg, core_debug_read_disable_reg, flash_erase_all}), 16'h0006);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(16'(core_debug_read_disable_reg), 16'(cfg_security_on));
  endtask

  task automatic wait_pulse(input bit t);
    int n;
    n = 0;
    do
      @(negedge clk);
    while ((t ? flash_timing_tick : flash_erase_done) !== 1'b1 && ++n < 3000);
    // a pulse that never came counts as a mismatch
    chk(16'(n >= 3000), 16'h0000);
    @(posedge clk);
  endtask

  task automatic period(input logic [15:0] e);
    int n;
    n = 0;
    wait_pulse(1'b1);
    do
    begin
      @(negedge clk);
      n++;
    end
    while (flash_timing_tick !== 1'b1 && n < 3000);
    @(posedge clk);
    chk(16'(n), e);
  endtask

  task automatic t_regs;
    rd_chk(`JLR_OFF_DIVIDER, 16'h0000);
    rd_chk(`JLR_OFF_PROTECT, 16'h0000);
    wr_reg(`JLR_OFF_DIVIDER, 16'hFFFF);
    rd_chk(`JLR_OFF_DIVIDER, 16'h007F);
    rd_chk(3'h7, 16'h0000);
    rd_chk(`JLR_OFF_STATUS, 16'h0004);
  endtask

  // prescale on, divider 3: 2*8*4 clocks a tick; a later update must not apply
  task automatic t_recovery;
    wr_reg(`JLR_OFF_PROTECT, 16'h00FF);
    wr_reg(`JLR_OFF_DIVIDER, 16'h0000);
    jlr_tap_master_i.tap_reset;
    jlr_tap_master_i.scan(1'b1, 7'h0B, 4);
    chk(16'(jlr_tap_master_i.cap[6:3]), 16'h0001);
    jlr_tap_master_i.scan(1'b0, 7'h43, 7);
    jlr_tap_master_i.scan(1'b0, 7'h00, 7);
    chk(16'(jlr_tap_master_i.cap), 16'h0043);
    period(16'd64);
    wait_pulse(1'b0);
    rd_chk(`JLR_OFF_STATUS, 16'h0005);
    chk(16'(core_debug_read_disable_reg), 16'h0001);
    jlr_tap_master_i.tap_reset;
    cfg_security_on <= 1'b0;
    chip_reset;
  endtask

  // no prescale, divider 24: 2*25 clocks a tick; test reset aborts
  task automatic t_abort;
    cfg_security_on <= 1'b1;
    chip_reset;
    jlr_tap_master_i.tap_reset;
    jlr_tap_master_i.scan(1'b1, 7'h0B, 4);
    jlr_tap_master_i.scan(1'b0, 7'h18, 7);
    period(16'd50);
    jlr_tap_master_i.tap_reset;
    chk(16'(flash_erase_all), 16'h0000);
    rd_chk(`JLR_OFF_STATUS, 16'h0004);
  endtask

  task automatic t_key;
    chip_reset;
    wr_reg(`JLR_OFF_KEY_ENTRY, 16'hA5C3);
    rd_chk(`JLR_OFF_STATUS, 16'h0004);
    chk(16'(core_debug_read_disable_reg), 16'h0001);
    backdoor_key_enable <= 1'b1;
    chip_reset;
    wr_reg(`JLR_OFF_KEY_ENTRY, 16'h5A3C);
    wr_reg(`JLR_OFF_KEY_ENTRY, 16'hA5C3);
    rd_chk(`JLR_OFF_STATUS, 16'h0006);
    chk(16'(core_debug_read_disable_reg), 16'h0000);
  endtask

  // software erase runs only with protection clear; done flag clears by command
  task automatic t_soft;
    wr_reg(`JLR_OFF_DIVIDER, 16'h0000);
    wr_reg(`JLR_OFF_COMMAND, 16'h0001);
    wait_pulse(1'b0);
    rd_chk(`JLR_OFF_STATUS, 16'h0007);
    wr_reg(`JLR_OFF_COMMAND, 16'h0002);
    rd_chk(`JLR_OFF_STATUS, 16'h0006);
    wr_reg(`JLR_OFF_PROTECT, 16'h0001);
    wr_reg(`JLR_OFF_COMMAND, 16'h0001);
    rd_chk(`JLR_OFF_STATUS, 16'h0006);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #2000000;
    fail_count++;
    complete_run;
  end

  initial
  begin
    chip_reset;
    t_regs;
    t_recovery;
    t_abort;
    t_key;
    t_soft;
    complete_run;
  end
endmodule
`default_nettype wire
